//--- design/thermal_pkg.sv
// Constants, types and register map of the thermal shutdown monitor.
package thermal_pkg;
   localparam int NCH = 8;
   localparam int CLK_FREQ_HZ = 125_000_000;
   localparam int CONV_PERIOD_MS = 250;
   localparam int CONV_PERIOD_CYCLES = CLK_FREQ_HZ / 1000 * CONV_PERIOD_MS;
   localparam int NORMAL_MEAS_MS = 21;
   localparam logic [2:0] EXT1_CH = 3'h1;
   localparam logic [7:0] TRIP_BASE = 8'h41;
   localparam logic [7:0] TRIP_MAX = 8'h7f;
   localparam logic [5:0] TRIP_MAX_CODE = 6'h3e;
   localparam logic [7:0] HW_RELEASE_DROP = 8'h0a;
   localparam logic [7:0] FAULT_VALUE = 8'h80;
   localparam logic [7:0] LIMIT_RESET = 8'h55;
   localparam logic [7:0] LOW_RESET = 8'h00;
   localparam logic [7:0] HYST_RESET = 8'h0a;
   localparam logic [7:0] CTRL_RESET = 8'h09;
   localparam logic [7:0] CH_EN_RESET = 8'hff;
   localparam logic [2:0] QUEUE_MAX = 3'h4;
   // Control register fields.
   localparam int CTRL_DYN = 0;
   localparam int CTRL_HOT_EVT = 1;
   localparam int CTRL_RATE_LSB = 2;
   // Status register fields.
   localparam int ST_HIGH = 0;
   localparam int ST_LOW = 1;
   localparam int ST_FAULT = 2;
   localparam int ST_HOT = 3;
   localparam int ST_SHDN = 4;
   // Register byte offsets.
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_LINK = 8'h04;
   localparam logic [7:0] ADDR_FILTER = 8'h08;
   localparam logic [7:0] ADDR_QUEUE = 8'h0c;
   localparam logic [7:0] ADDR_HYST = 8'h10;
   localparam logic [7:0] ADDR_HOT_SEL = 8'h14;
   localparam logic [7:0] ADDR_STATUS = 8'h18;
   localparam logic [7:0] ADDR_MASK = 8'h1c;
   localparam logic [7:0] ADDR_SHDN = 8'h20;
   localparam logic [7:0] ADDR_HOTTEST = 8'h24;
   localparam logic [7:0] ADDR_CH_EN = 8'h28;
   // Per-channel groups: byte address = group * 32 + channel * 4.
   localparam logic [2:0] GRP_TEMP = 3'h2;
   localparam logic [2:0] GRP_CRIT = 3'h3;
   localparam logic [2:0] GRP_HIGH = 3'h4;
   localparam logic [2:0] GRP_LOW = 3'h5;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {
      RATE_1PS = 2'b00,
      RATE_2PS = 2'b01,
      RATE_4PS = 2'b10,
      RATE_CONT = 2'b11
   } rate_t;

   typedef enum logic [1:0] {
      MT_HALF = 2'b00,
      MT_1X = 2'b01,
      MT_2X = 2'b10,
      MT_4X = 2'b11
   } meas_time_t;

   typedef struct packed {
      logic [2:0] ch;
      logic [7:0] temp;
      logic fault;
   } meas_t;

   typedef struct packed {
      logic open;
      logic [5:0] code;
   } trip_t;
endpackage

//--- design/thermal_shutdown_monitor.sv
// Temperature monitor with hardware shutdown and AXI4-Lite registers.
`timescale 1ns/1ns
`default_nettype none
module thermal_shutdown_monitor
#(
   parameter int CONV_BASE_CYCLES = thermal_pkg::CONV_PERIOD_CYCLES
)
(
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write channels.
   input wire logic [31:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read channels.
   input wire logic [31:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Measurement front end.
   input wire logic meas_valid,
   input wire thermal_pkg::meas_t meas,
   input wire logic meas_cycle_end,
   output logic conv_start,
   output thermal_pkg::meas_time_t meas_time,
   // Threshold pin level, already digitised.
   input wire thermal_pkg::trip_t threshold_select_input,
   // Shutdown and interrupt.
   output logic system_shutdown_out_n,
   output logic irq
);
   import thermal_pkg::*;
   logic [7:0] ctrl, link, filter, hyst, hot_sel, status, mask, ch_en;
   logic [3:0] queue;
   logic [7:0] hw_thr, hot_temp, hot_oh;
   logic [31:0] aw_q, w_q;
   logic [3:0] strb_q;
   logic [31:0] conv_cnt;
   logic kick, shdn_act, end_q;
   logic [2:0] hw_cnt;
   trip_t trip_meta, trip_sync;
   wire logic [7:0] temp_v [NCH];
   wire logic [7:0] crit_v [NCH];
   wire logic [7:0] high_v [NCH];
   wire logic [7:0] low_v [NCH];
   wire logic [NCH-1:0] hi_trip, lo_trip, ft_trip, cr_trip, rel_ok, faulted;
   function automatic logic [2:0] next_cnt(input logic c, input logic [2:0] n);
      next_cnt = !c ? 3'h0 : (n == QUEUE_MAX) ? QUEUE_MAX : n + 3'h1;
   endfunction
   // Register write decode; a write happens once address and data are held.
   wire logic wr_fire = !awready && !wready && !bvalid;
   wire logic [7:0] wa = aw_q[7:0];
   wire logic [2:0] wg = wa[7:5];
   wire logic [2:0] wi = wa[4:2];
   wire logic wa_ok = aw_q[31:8] == 24'h0 && wa[1:0] == 2'b00;
   wire logic w_grp = wa_ok && (wg == GRP_CRIT || wg == GRP_HIGH ||
      wg == GRP_LOW);
   wire logic w_scal = wa_ok && (wa == ADDR_CTRL || wa == ADDR_LINK ||
      wa == ADDR_FILTER || wa == ADDR_QUEUE || wa == ADDR_HYST ||
      wa == ADDR_HOT_SEL || wa == ADDR_STATUS || wa == ADDR_MASK ||
      wa == ADDR_CH_EN);
   wire logic wr_map = w_grp || w_scal;
   wire logic wr_en = wr_fire && wr_map && strb_q[0];
   wire logic [7:0] wd = w_q[7:0];
   wire logic [7:0] st_clr = (wr_en && wa == ADDR_STATUS) ? wd : 8'h00;
   // Queue lengths one to four, separately for alert and shutdown.
   wire logic [2:0] shdn_len = {1'b0, queue[1:0]} + 3'h1;
   wire logic [2:0] alert_len = {1'b0, queue[3:2]} + 3'h1;
   wire logic take = meas_valid && ch_en[meas.ch];
   rate_t rate;
   assign rate = rate_t'(ctrl[CTRL_RATE_LSB +: 2]);
   // One slice per channel: reported value, averaging except on channel 0, counters, limits.
   for (genvar i = 0; i < NCH; i++)
   begin : chan
      logic [7:0] t, cr, hl, ll;
      logic [7:0] h [3];
      logic [2:0] c_hi, c_lo, c_ft, c_cr;
      logic flt;
      wire logic hit = take && meas.ch == 3'(i);
      wire logic [9:0] sum = 10'(meas.temp) + 10'(h[0]) + 10'(h[1]) +
         10'(h[2]);
      wire logic avg_on = filter[i] && i != 0;
      wire logic [7:0] v = meas.fault ? FAULT_VALUE :
         (avg_on ? sum[9:2] : meas.temp);
      wire logic is_hi = !meas.fault && v >= hl;
      wire logic is_lo = !meas.fault && v < ll;
      wire logic is_cr = !meas.fault && v > cr;
      wire logic [2:0] n_hi = next_cnt(is_hi, c_hi);
      wire logic [2:0] n_lo = next_cnt(is_lo, c_lo);
      wire logic [2:0] n_ft = next_cnt(meas.fault, c_ft);
      wire logic [2:0] n_cr = next_cnt(is_cr, c_cr);
      wire logic wsel = wr_en && w_grp && wi == 3'(i);
      always_ff @(posedge aclk)
      begin
         if (!aresetn)
         begin
            t <= 8'h00;
            h <= '{default: 8'h00};
            c_hi <= 3'h0;
            c_lo <= 3'h0;
            c_ft <= 3'h0;
            c_cr <= 3'h0;
            flt <= 1'b0;
            cr <= LIMIT_RESET;
            hl <= LIMIT_RESET;
            ll <= LOW_RESET;
         end
         else
         begin
            if (hit)
            begin
               t <= v;
               flt <= meas.fault;
               c_hi <= n_hi;
               c_lo <= n_lo;
               c_ft <= n_ft;
               c_cr <= n_cr;
               if (!meas.fault)
               begin
                  h[0] <= meas.temp;
                  h[1] <= h[0];
                  h[2] <= h[1];
               end
            end
            if (wsel && wg == GRP_CRIT)
               cr <= wd;
            if (wsel && wg == GRP_HIGH)
               hl <= wd;
            if (wsel && wg == GRP_LOW)
               ll <= wd;
         end
      end
      assign hi_trip[i] = hit && n_hi >= alert_len;
      assign lo_trip[i] = hit && n_lo >= alert_len;
      assign ft_trip[i] = hit && n_ft >= alert_len;
      assign cr_trip[i] = hit && link[i] && n_cr >= shdn_len;
      assign rel_ok[i] = !link[i] ||
         ({1'b0, t} + {1'b0, hyst} < {1'b0, cr});
      assign faulted[i] = flt;
      assign temp_v[i] = t;
      assign crit_v[i] = cr;
      assign high_v[i] = hl;
      assign low_v[i] = ll;
   end

   // Hardware threshold path of external channel 1.
   wire logic hw_hit = take && meas.ch == EXT1_CH;
   wire logic hw_over = !meas.fault && chan[1].v > hw_thr;
   wire logic [2:0] hw_next = next_cnt(hw_over, hw_cnt);
   wire logic hw_trip = hw_hit && hw_next >= shdn_len;
   wire logic shdn_set = hw_trip || |cr_trip;
   wire logic shdn_rel = temp_v[1] < hw_thr - HW_RELEASE_DROP &&
      &rel_ok;
   wire logic next_shdn = shdn_set ? 1'b1 : (shdn_rel ? 1'b0 : shdn_act);
   // Threshold decode: one degree per code step, open pin gives minimum.
   wire logic [7:0] thr_dec = trip_sync.open ? TRIP_BASE :
      (trip_sync.code >= TRIP_MAX_CODE) ? TRIP_MAX :
      TRIP_BASE + {2'b00, trip_sync.code};
   // Hottest of selected channels, judged once the last sample is stored.
   wire logic [NCH-1:0] cand = hot_sel & ch_en & ~faulted;
   logic [7:0] best_t, best_oh;
   always_comb
   begin
      best_t = 8'h00;
      best_oh = 8'h00;
      for (int k = 1; k < NCH; k++)
      begin
         if (cand[k] && (best_oh == 8'h00 || temp_v[k] > best_t))
         begin
            best_t = temp_v[k];
            best_oh = 8'h00;
            best_oh[k] = 1'b1;
         end
      end
   end
   wire logic hot_upd = end_q && best_oh != 8'h00;
   wire logic hot_chg = hot_upd && ctrl[CTRL_HOT_EVT] &&
      hot_oh != 8'h00 && best_oh != hot_oh;
   // Status events; a new event wins over a clear in the same cycle.
   wire logic [7:0] st_set = {3'b000, shdn_set && !shdn_act, hot_chg,
      |ft_trip, |lo_trip, |hi_trip};
   wire logic [7:0] next_status = (status & ~st_clr) | st_set;
   // Conversion timing and measurement length per rate.
   wire logic [31:0] period = (rate == RATE_1PS) ?
      32'(CONV_BASE_CYCLES) << 2 : (rate == RATE_2PS) ?
      32'(CONV_BASE_CYCLES) << 1 : 32'(CONV_BASE_CYCLES);
   meas_time_t next_mt;
   assign next_mt = (rate == RATE_CONT) ? MT_HALF :
      !ctrl[CTRL_DYN] ? MT_1X : (rate == RATE_1PS) ? MT_4X :
      (rate == RATE_2PS) ? MT_2X : MT_1X;
   wire logic tick = (rate == RATE_CONT) ? (meas_cycle_end || kick) :
      conv_cnt == 32'h0;
   // Read decode.
   wire logic [7:0] ra = araddr[7:0];
   wire logic [2:0] rg = ra[7:5];
   wire logic [2:0] ri = ra[4:2];
   wire logic ra_ok = araddr[31:8] == 24'h0 && ra[1:0] == 2'b00;
   wire logic r_grp = ra_ok && (rg == GRP_TEMP || rg == GRP_CRIT ||
      rg == GRP_HIGH || rg == GRP_LOW);
   wire logic [7:0] r_grp_d = (rg == GRP_TEMP) ? temp_v[ri] :
      (rg == GRP_CRIT) ? crit_v[ri] : (rg == GRP_HIGH) ? high_v[ri] :
      low_v[ri];
   wire logic [7:0] r_scal_d = (ra == ADDR_CTRL) ? ctrl :
      (ra == ADDR_LINK) ? link : (ra == ADDR_FILTER) ? filter :
      (ra == ADDR_QUEUE) ? {4'h0, queue} : (ra == ADDR_HYST) ? hyst :
      (ra == ADDR_HOT_SEL) ? hot_sel : (ra == ADDR_STATUS) ? status :
      (ra == ADDR_MASK) ? mask : (ra == ADDR_CH_EN) ? ch_en : 8'h00;
   wire logic r_scal = ra_ok && (ra == ADDR_CTRL || ra == ADDR_LINK ||
      ra == ADDR_FILTER || ra == ADDR_QUEUE || ra == ADDR_HYST ||
      ra == ADDR_HOT_SEL || ra == ADDR_STATUS || ra == ADDR_MASK ||
      ra == ADDR_CH_EN);
   wire logic r_wide = ra_ok && (ra == ADDR_SHDN || ra == ADDR_HOTTEST);
   wire logic [31:0] r_wide_d = (ra == ADDR_SHDN) ?
      {16'h0, hw_thr, 7'h00, shdn_act} : {16'h0, hot_oh, hot_temp};
   wire logic [31:0] rd_word = r_grp ? {24'h0, r_grp_d} :
      r_wide ? r_wide_d : {24'h0, r_scal_d};
   wire logic rd_map = r_grp || r_scal || r_wide;
   // AXI4-Lite slave handshakes.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready <= 1'b1;
         wready <= 1'b1;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
         aw_q <= 32'h0;
         w_q <= 32'h0;
         strb_q <= 4'h0;
      end
      else
      begin
         if (awvalid && awready)
         begin
            aw_q <= awaddr;
            awready <= 1'b0;
         end
         if (wvalid && wready)
         begin
            w_q <= wdata;
            strb_q <= wstrb;
            wready <= 1'b0;
         end
         if (wr_fire)
         begin
            bvalid <= 1'b1;
            bresp <= wr_map ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid && bready)
         begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h0;
         rresp <= RESP_OKAY;
      end
      else if (arvalid && arready)
      begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= rd_map ? rd_word : 32'h0;
         rresp <= rd_map ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rvalid && rready)
      begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end

   // Software registers.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl <= CTRL_RESET;
         link <= 8'h00;
         filter <= 8'h00;
         queue <= 4'h0;
         hyst <= HYST_RESET;
         hot_sel <= 8'h00;
         mask <= 8'h00;
         ch_en <= CH_EN_RESET;
      end
      else if (wr_en)
      begin
         if (wa == ADDR_CTRL)
            ctrl <= {4'h0, wd[3:0]};
         if (wa == ADDR_LINK)
            link <= wd;
         if (wa == ADDR_FILTER)
            filter <= wd;
         if (wa == ADDR_QUEUE)
            queue <= wd[3:0];
         if (wa == ADDR_HYST)
            hyst <= wd;
         if (wa == ADDR_HOT_SEL)
            hot_sel <= {wd[7:1], 1'b0};
         if (wa == ADDR_MASK)
            mask <= wd;
         if (wa == ADDR_CH_EN)
            ch_en <= wd;
      end
   end

   // Threshold pin synchroniser; the decoded value is held per conversion.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         trip_meta <= '0;
         trip_sync <= '0;
         hw_thr <= TRIP_BASE;
      end
      else
      begin
         trip_meta <= threshold_select_input;
         trip_sync <= trip_meta;
         if (tick)
            hw_thr <= thr_dec;
      end
   end

   // Conversion scheduler.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         conv_cnt <= 32'h0;
         kick <= 1'b1;
         conv_start <= 1'b0;
         meas_time <= MT_1X;
      end
      else
      begin
         kick <= 1'b0;
         conv_start <= tick;
         meas_time <= next_mt;
         conv_cnt <= (tick || rate == RATE_CONT) ? period - 32'h1 :
            conv_cnt - 32'h1;
      end
   end

   // Shutdown latch, hottest tracking, status and interrupt.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         hw_cnt <= 3'h0;
         shdn_act <= 1'b0;
         system_shutdown_out_n <= 1'b1;
         hot_temp <= 8'h00;
         hot_oh <= 8'h00;
         status <= 8'h00;
         irq <= 1'b0;
         end_q <= 1'b0;
      end
      else
      begin
         if (hw_hit)
            hw_cnt <= hw_next;
         shdn_act <= next_shdn;
         system_shutdown_out_n <= !next_shdn;
         if (hot_upd)
         begin
            hot_temp <= best_t;
            hot_oh <= best_oh;
         end
         status <= next_status;
         irq <= |(next_status & ~mask);
         end_q <= meas_cycle_end;
      end
   end
endmodule
`default_nettype wire

//--- test/meas_source.sv
// Front end model that delivers one sample per channel each cycle.
`timescale 1ns/1ns
`default_nettype none
module meas_source
(
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Sample values set by the bench.
   input wire logic [63:0] temps,
   input wire logic [7:0] faults,
   // Conversion handshake.
   input wire logic conv_start,
   output logic meas_valid,
   output thermal_pkg::meas_t meas,
   output logic meas_cycle_end
);
   import thermal_pkg::*;
   logic [3:0] idx;
   always_ff @(posedge aclk)
   begin
      meas_valid <= 1'b0;
      meas_cycle_end <= 1'b0;
      // An idle bus inverts every bit each clock, so it alternates between the stale sample and its inverse.
      meas <= ~meas;
      if (!aresetn)
         idx <= 4'h8;
      else if (conv_start)
         idx <= 4'h0;
      else if (idx < 4'h8)
      begin
         meas_valid <= 1'b1;
         meas <= '{idx[2:0], temps[idx*8 +: 8], faults[idx]};
         meas_cycle_end <= idx == 4'h7;
         idx <= idx + 4'h1;
      end
   end
endmodule
`default_nettype wire

//--- test/thermal_shutdown_monitor_assertions.sv
// Port checker for the thermal shutdown monitor.
`timescale 1ns/1ns
`default_nettype none
module thermal_shutdown_monitor_assertions
(
   // Watched ports.
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic meas_valid,
   input wire thermal_pkg::meas_t meas,
   input wire logic conv_start,
   input wire thermal_pkg::meas_time_t meas_time,
   input wire logic system_shutdown_out_n
);
   import thermal_pkg::*;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_wr_taken;
      awvalid && awready && wvalid && wready;
   endsequence
   property p_rst;
      disable iff (1'b0) !aresetn |=> awready && arready && !bvalid &&
         !rvalid && system_shutdown_out_n && !conv_start;
   endproperty
   property p_wr_resp;
      s_wr_taken |-> ##[1:2] bvalid;
   endproperty
   property p_rd_resp;
      arvalid && arready |=> rvalid;
   endproperty
   property p_wr_busy;
      bvalid |-> !awready && !wready;
   endproperty
   property p_rd_busy;
      rvalid |-> !arready;
   endproperty
   property p_err_zero;
      rvalid && rresp == RESP_SLVERR |-> rdata == 32'h0;
   endproperty
   property p_trip_cause;
      $fell(system_shutdown_out_n) |-> $past(meas_valid && !meas.fault);
   endproperty
   property p_conv_pulse;
      conv_start |=> !conv_start;
   endproperty
   property p_mt_write;
      $changed(meas_time) |-> bvalid || $past(bvalid);
   endproperty
   a_rst: assert property (p_rst) else $error("bad reset outputs");
   a_wr_resp: assert property (p_wr_resp) else $error("no write answer");
   a_rd_resp: assert property (p_rd_resp) else $error("no read answer");
   a_wr_busy: assert property (p_wr_busy) else $error("write ready early");
   a_rd_busy: assert property (p_rd_busy) else $error("read ready early");
   a_err_zero: assert property (p_err_zero) else $error("error data");
   a_trip_cause: assert property (p_trip_cause)
      else $error("shutdown without valid sample");
   a_conv_pulse: assert property (p_conv_pulse)
      else $error("conversion start too long");
   a_mt_write: assert property (p_mt_write)
      else $error("measurement time moved alone");
endmodule
bind thermal_shutdown_monitor thermal_shutdown_monitor_assertions i_chk (
   .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
   .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .arvalid(arvalid),
   .arready(arready), .rvalid(rvalid), .rdata(rdata), .rresp(rresp),
   .meas_valid(meas_valid), .meas(meas), .conv_start(conv_start),
   .meas_time(meas_time), .system_shutdown_out_n(system_shutdown_out_n)
);
`default_nettype wire

//--- test/tb_top.sv
// Self-checking bench for the thermal shutdown monitor.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import thermal_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, rd, ex;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid, mv, mend, cs, shdn_n, irq;
   logic [3:0] wstrb = 4'hf;
   logic [1:0] bresp, rresp, rsp;
   meas_t meas;
   meas_time_t mt;
   trip_t trip = '{1'b1, 6'h00};
   logic [63:0] temps = {8{8'h20}};
   logic [7:0] faults = 8'h00;
   logic [5:0] codes [4] = '{6'h00, 6'h3d, 6'h3f, 6'h05};
   int err_count = 0;
   int num_checks = 0;
   always #4 aclk = ~aclk;
   thermal_shutdown_monitor #(.CONV_BASE_CYCLES(50)) i_dut (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready), .meas_valid(mv),
      .meas(meas), .meas_cycle_end(mend), .conv_start(cs), .meas_time(mt),
      .threshold_select_input(trip), .system_shutdown_out_n(shdn_n),
      .irq(irq));
   meas_source i_src (.aclk(aclk), .aresetn(aresetn), .temps(temps),
      .faults(faults), .conv_start(cs), .meas_valid(mv), .meas(meas),
      .meas_cycle_end(mend));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      if (err_count == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Ready is read at the falling edge so the rising-edge sample is known.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw, w, b;
      @(posedge aclk);
      awaddr <= {24'h0, a};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(negedge aclk);
         aw = awvalid && awready;
         w = wvalid && wready;
         b = bvalid;
         rsp = bresp;
         @(posedge aclk);
         if (aw) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
         if (b) bready <= 1'b0;
      end while (!b);
   endtask
   task automatic rd_reg(input logic [7:0] a);
      logic ar, r;
      @(posedge aclk);
      araddr <= {24'h0, a};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(negedge aclk);
         ar = arvalid && arready;
         r = rvalid;
         rd = rdata;
         rsp = rresp;
         @(posedge aclk);
         if (ar) arvalid <= 1'b0;
         if (r) rready <= 1'b0;
      end while (!r);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mend);
      repeat (3) @(negedge aclk);
   endtask
   task automatic set_t(input int ch, input logic [7:0] v);
      @(posedge aclk);
      temps[ch*8 +: 8] <= v;
   endtask
   initial
   begin
      #200000;
      err_count++;
      end_sim();
   end
   initial
   begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(negedge aclk);
      check(mt, MT_1X);
      rd_reg(ADDR_CTRL);
      check(rd, 32'h9);
      rd_reg(ADDR_FILTER);
      check(rd, 32'h0);
      rd_reg(ADDR_CH_EN);
      check(rd, 32'hff);
      cyc(1);
      rd_reg(ADDR_SHDN);
      check(rd, 32'h4100);
      rd_reg({GRP_TEMP, 5'h1c});
      check(rd, 32'h20);
      rd_reg(8'hfc);
      check(rsp, RESP_SLVERR);
      check(rd, 32'h0);
      wr(8'hfc, 32'h0);
      check(rsp, RESP_SLVERR);
      for (int i = 0; i < 8; i++)
      begin
         wr(ADDR_CTRL, {28'h0, i[1:0], 1'b0, i[2]});
         repeat (2) @(negedge aclk);
         ex = i[1:0] == 2'b11 ? MT_HALF : !i[2] ? MT_1X : MT_4X - i[1:0];
         check(mt, ex);
      end
      wr(ADDR_CTRL, 32'h9);
      for (int i = 0; i < 4; i++)
      begin
         @(posedge aclk);
         trip <= '{1'b0, codes[i]};
         cyc(2);
         rd_reg(ADDR_SHDN);
         ex = codes[i] >= 6'h3e ? TRIP_MAX : TRIP_BASE + codes[i];
         check(rd[15:8], ex);
      end
      wr(ADDR_MASK, 32'h1f);
      wr(ADDR_QUEUE, 32'h1);
      set_t(1, 8'h47);
      cyc(1);
      check(shdn_n, 1'b1);
      set_t(1, 8'h46);
      cyc(1);
      set_t(1, 8'h47);
      cyc(1);
      check(shdn_n, 1'b1);
      cyc(1);
      check(shdn_n, 1'b0);
      check(irq, 1'b0);
      rd_reg(ADDR_STATUS);
      check(rd[ST_SHDN], 1'b1);
      set_t(1, 8'h3c);
      cyc(2);
      check(shdn_n, 1'b0);
      set_t(1, 8'h3b);
      cyc(1);
      check(shdn_n, 1'b1);
      @(posedge aclk);
      faults <= 8'h02;
      cyc(2);
      check(shdn_n, 1'b1);
      rd_reg({GRP_TEMP, 5'h04});
      check(rd, 32'h80);
      rd_reg(ADDR_STATUS);
      check(rd[ST_FAULT], 1'b1);
      @(posedge aclk);
      faults <= 8'h00;
      wr(ADDR_MASK, 32'h0);
      @(negedge aclk);
      check(irq, 1'b1);
      cyc(1);
      wr(ADDR_STATUS, 32'h1f);
      @(negedge aclk);
      check(irq, 1'b0);
      wr(ADDR_LINK, 32'h8);
      wr({GRP_CRIT, 5'h0c}, 32'h50);
      set_t(3, 8'h51);
      cyc(2);
      check(shdn_n, 1'b0);
      set_t(3, 8'h46);
      cyc(1);
      check(shdn_n, 1'b0);
      set_t(3, 8'h45);
      cyc(1);
      check(shdn_n, 1'b1);
      wr(ADDR_FILTER, 32'h4);
      set_t(2, 8'h28);
      cyc(4);
      set_t(2, 8'h50);
      cyc(1);
      rd_reg({GRP_TEMP, 5'h08});
      check(rd, 32'h32);
      wr(ADDR_HOT_SEL, 32'h30);
      set_t(4, 8'h30);
      set_t(5, 8'h38);
      cyc(1);
      rd_reg(ADDR_HOTTEST);
      check(rd, 32'h2038);
      wr(ADDR_CTRL, 32'hb);
      set_t(4, 8'h40);
      cyc(1);
      rd_reg(ADDR_STATUS);
      check(rd[ST_HOT], 1'b1);
      end_sim();
   end
endmodule
`default_nettype wire
